// >>> hdl/conn_matrix_pkg.sv
// Shared constants and types for the 64 kbit/s channel connection matrix.
// Assumes every connection point is addressed by a port index of PORT_W bits.
package conn_matrix_pkg;

    localparam int          PORT_W     = 3;
    localparam int          OCTET_BITS = 8;
    localparam int          FIFO_DEPTH = 32;
    localparam logic [2:0]  BIT_FIRST  = 3'h0;
    localparam logic [2:0]  BIT_LAST   = 3'h7;
    localparam logic [7:0]  IDLE_ALAW  = 8'hd5;
    localparam logic [7:0]  IDLE_MULAW = 8'hff;

    typedef enum logic {CMD_CONNECT, CMD_DISCONNECT} cmd_op_e;
    typedef enum logic {DIR_UNI, DIR_BI} conn_direction_e;
    typedef enum logic {LAW_A, LAW_MU} idle_law_e;

    typedef struct packed {
        cmd_op_e             op;
        logic [PORT_W-1:0]   in_id;
        logic [PORT_W-1:0]   out_id;
        conn_direction_e     conn_direction;
        idle_law_e           law;
    } conn_cmd_s;

    typedef struct packed {
        logic                connected;
        logic [PORT_W-1:0]   src;
        conn_direction_e     conn_direction;
        idle_law_e           law;
    } conn_entry_s;

    typedef struct packed {
        logic [PORT_W-1:0]   port;
        logic [7:0]          data;
        logic                server_fail;
    } octet_s;

    localparam int OCTET_W = $bits(octet_s);

    localparam conn_entry_s ENTRY_IDLE = '{connected: 1'b0, src: '0, conn_direction: DIR_UNI, law: LAW_A};

endpackage : conn_matrix_pkg

// >>> hdl/octet_fifo.sv
// Synchronous FIFO with valid/ready handshakes on both sides.
// Assumes both sides run on clk_sys.
`timescale 1ns/10ps
`default_nettype none
module octet_fifo
    import conn_matrix_pkg::*;
#(
    parameter int WIDTH = OCTET_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        wr_ptr_next = push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next  = (AW+1)'(count_reg + (AW+1)'(push) - (AW+1)'(pop));
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
        if (reset)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

endmodule : octet_fifo
`default_nettype wire

// >>> hdl/channel_connection_matrix.sv
// Connection matrix for byte-structured 64 kbit/s channels with retimed outputs.
// Assumes channel pins and the timing reference are asynchronous to clk_sys and far slower than it.
`timescale 1ns/10ps
`default_nettype none
module channel_connection_matrix
    import conn_matrix_pkg::*;
#(
    parameter int N_PORTS   = 8,
    parameter int N_SOURCES = 4
)
(
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // Input connection points
    input  wire logic [N_PORTS-1:0]   in_bit_clock,
    input  wire logic [N_PORTS-1:0]   in_data,
    input  wire logic [N_PORTS-1:0]   in_frame_start,
    input  wire logic [N_PORTS-1:0]   in_server_fail,
    // Timing reference
    input  wire logic                 timing_ref_clock,
    input  wire logic                 timing_ref_frame_start,
    // Output connection points
    output logic      [N_PORTS-1:0]   out_bit_clock,
    output logic      [N_PORTS-1:0]   out_data,
    output logic      [N_PORTS-1:0]   out_frame_start,
    output logic      [N_PORTS-1:0]   out_server_fail,
    // Sink activation
    input  wire logic [N_PORTS-1:0]   sink_active,
    // Source access to the access point
    input  wire logic [N_SOURCES-1:0] source_request,
    output logic      [N_SOURCES-1:0] source_grant,
    // Management
    input  wire logic                 cmd_valid,
    input  wire conn_cmd_s            cmd,
    output logic                      cmd_done,
    output logic                      cmd_error
);

    localparam int SW = 4 * N_PORTS + 2;

    // Pin synchronisers.
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [SW-1:0] prev_reg;
    logic [N_PORTS-1:0] ch_clk;
    logic [N_PORTS-1:0] ch_dat;
    logic [N_PORTS-1:0] ch_fs;
    logic [N_PORTS-1:0] ch_ssf;
    logic [N_PORTS-1:0] ch_rise;
    logic ref_clk;
    logic ref_fs;
    logic ref_rise;
    logic load;

    always_ff @(posedge clk_sys)
    begin
        sync1_reg <= {timing_ref_frame_start, timing_ref_clock, in_server_fail, in_frame_start, in_data, in_bit_clock};
        sync2_reg <= sync1_reg;
        prev_reg  <= sync2_reg;
    end

    assign ch_clk   = sync2_reg[N_PORTS-1:0];
    assign ch_dat   = sync2_reg[2*N_PORTS-1:N_PORTS];
    assign ch_fs    = sync2_reg[3*N_PORTS-1:2*N_PORTS];
    assign ch_ssf   = sync2_reg[4*N_PORTS-1:3*N_PORTS];
    assign ref_clk  = sync2_reg[4*N_PORTS];
    assign ref_fs   = sync2_reg[4*N_PORTS+1];
    assign ch_rise  = ch_clk & ~prev_reg[N_PORTS-1:0];
    assign ref_rise = ref_clk && !prev_reg[4*N_PORTS];
    assign load     = ref_rise && ref_fs;

    // Input octet capture.
    logic [7:0]          shift_reg     [N_PORTS];
    logic [7:0]          shift_next    [N_PORTS];
    logic [2:0]          bitcnt_reg    [N_PORTS];
    logic [2:0]          bitcnt_next   [N_PORTS];
    logic [N_PORTS-1:0]  aligned_reg;
    logic [N_PORTS-1:0]  aligned_next;
    logic [N_PORTS-1:0]  pend_reg;
    logic [N_PORTS-1:0]  pend_next;
    logic [7:0]          pdata_reg     [N_PORTS];
    logic [7:0]          pdata_next    [N_PORTS];
    logic [N_PORTS-1:0]  pssf_reg;
    logic [N_PORTS-1:0]  pssf_next;
    logic [PORT_W-1:0]   scan_reg;
    logic [PORT_W-1:0]   scan_next;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    octet_s              fifo_in;
    octet_s              fifo_out;
    logic                push_ok;

    assign fifo_in = '{port: scan_reg, data: pdata_reg[scan_reg], server_fail: pssf_reg[scan_reg]};
    assign push_ok = pend_reg[scan_reg] && fifo_in_ready;

    always_comb
    begin
        pend_next    = pend_reg;
        pssf_next    = pssf_reg;
        aligned_next = aligned_reg;
        pdata_next   = pdata_reg;
        shift_next   = shift_reg;
        bitcnt_next  = bitcnt_reg;
        scan_next    = scan_reg;
        if (push_ok)
        begin
            pend_next[scan_reg] = 1'b0;
        end
        if (push_ok || !pend_reg[scan_reg])
        begin
            scan_next = (int'(scan_reg) == N_PORTS - 1) ? '0 : PORT_W'(scan_reg + 1'b1);
        end
        for (int p = 0; p < N_PORTS; p++)
        begin
            if (ch_rise[p])
            begin
                shift_next[p] = {shift_reg[p][6:0], ch_dat[p]};
                if (ch_fs[p])
                begin
                    bitcnt_next[p]  = BIT_FIRST;
                    aligned_next[p] = 1'b1;
                end
                else
                begin
                    bitcnt_next[p] = 3'(bitcnt_reg[p] + 1'b1);
                end
                if (!ch_fs[p] && aligned_reg[p] && bitcnt_reg[p] == 3'(BIT_LAST - 1'b1))
                begin
                    pend_next[p]  = 1'b1;
                    pdata_next[p] = {shift_reg[p][6:0], ch_dat[p]};
                    pssf_next[p]  = ch_ssf[p];
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pend_reg    <= '0;
            pssf_reg    <= '0;
            aligned_reg <= '0;
            scan_reg    <= '0;
            for (int p = 0; p < N_PORTS; p++)
            begin
                shift_reg[p]  <= '0;
                bitcnt_reg[p] <= BIT_FIRST;
                pdata_reg[p]  <= '0;
            end
        end
        else
        begin
            pend_reg    <= pend_next;
            pssf_reg    <= pssf_next;
            aligned_reg <= aligned_next;
            scan_reg    <= scan_next;
            shift_reg   <= shift_next;
            bitcnt_reg  <= bitcnt_next;
            pdata_reg   <= pdata_next;
        end
    end

    octet_fifo #(
        .WIDTH (OCTET_W),
        .DEPTH (FIFO_DEPTH)
    ) octet_fifo_inst (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (pend_reg[scan_reg]),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out)
    );

    // The store is not written while outputs load, so every broadcast leg sees one snapshot.
    assign fifo_out_ready = !load;

    logic [7:0]         store_data_reg [N_PORTS];
    logic [7:0]         store_data_next[N_PORTS];
    logic [N_PORTS-1:0] store_ssf_reg;
    logic [N_PORTS-1:0] store_ssf_next;

    always_comb
    begin
        store_data_next = store_data_reg;
        store_ssf_next  = store_ssf_reg;
        if (fifo_out_valid && fifo_out_ready)
        begin
            store_data_next[fifo_out.port] = fifo_out.data;
            store_ssf_next[fifo_out.port]  = fifo_out.server_fail;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            store_ssf_reg <= '1;
            for (int p = 0; p < N_PORTS; p++)
            begin
                store_data_reg[p] <= IDLE_ALAW;
            end
        end
        else
        begin
            store_data_reg <= store_data_next;
            store_ssf_reg  <= store_ssf_next;
        end
    end

    // Connection map, one entry per output.
    conn_entry_s map_reg [N_PORTS];
    conn_entry_s map_next[N_PORTS];
    logic        done_next;
    logic        err_next;
    logic        done_reg;
    logic        err_reg;
    logic        ids_ok;
    conn_entry_s old;

    assign ids_ok = (int'(cmd.in_id) < N_PORTS) && (int'(cmd.out_id) < N_PORTS);

    always_comb
    begin
        map_next  = map_reg;
        done_next = cmd_valid;
        err_next  = cmd_valid && !ids_ok;
        old       = map_reg[cmd.out_id];
        if (cmd_valid && ids_ok)
        begin
            unique case (cmd.op)
                CMD_CONNECT:
                begin
                    map_next[cmd.out_id] = '{1'b1, cmd.in_id, cmd.conn_direction, cmd.law};
                    if (cmd.conn_direction == DIR_BI)
                    begin
                        map_next[cmd.in_id] = '{1'b1, cmd.out_id, DIR_BI, cmd.law};
                    end
                end
                CMD_DISCONNECT:
                begin
                    if (old.connected && old.conn_direction == DIR_BI && map_reg[old.src].src == cmd.out_id)
                    begin
                        map_next[old.src] = '{1'b0, '0, DIR_UNI, map_reg[old.src].law};
                    end
                    map_next[cmd.out_id] = '{1'b0, '0, DIR_UNI, cmd.law};
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            done_reg <= 1'b0;
            err_reg  <= 1'b0;
            for (int p = 0; p < N_PORTS; p++)
            begin
                map_reg[p] <= ENTRY_IDLE;
            end
        end
        else
        begin
            done_reg <= done_next;
            err_reg  <= err_next;
            map_reg  <= map_next;
        end
    end

    // Retimed outputs.
    logic [7:0]         oshift_reg [N_PORTS];
    logic [7:0]         oshift_next[N_PORTS];
    logic [N_PORTS-1:0] odata_reg;
    logic [N_PORTS-1:0] odata_next;
    logic [N_PORTS-1:0] ossf_reg;
    logic [N_PORTS-1:0] ossf_next;
    logic [N_PORTS-1:0] ofs_reg;
    logic [N_PORTS-1:0] ofs_next;
    logic [N_PORTS-1:0] oclk_reg;

    always_comb
    begin
        oshift_next = oshift_reg;
        odata_next  = odata_reg;
        ossf_next   = ossf_reg;
        ofs_next    = ofs_reg;
        for (int o = 0; o < N_PORTS; o++)
        begin
            if (load)
            begin
                if (map_reg[o].connected)
                begin
                    oshift_next[o] = store_data_reg[map_reg[o].src];
                    ossf_next[o]   = store_ssf_reg[map_reg[o].src] && sink_active[o];
                end
                else
                begin
                    oshift_next[o] = (map_reg[o].law == LAW_MU) ? IDLE_MULAW : IDLE_ALAW;
                    ossf_next[o]   = 1'b0;
                end
                odata_next[o] = oshift_next[o][7];
            end
            else if (ref_rise)
            begin
                oshift_next[o] = {oshift_reg[o][6:0], 1'b0};
                odata_next[o]  = oshift_reg[o][6];
            end
            if (ref_rise)
            begin
                ofs_next[o] = ref_fs;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            odata_reg <= '0;
            ossf_reg  <= '0;
            ofs_reg   <= '0;
            oclk_reg  <= '0;
            for (int o = 0; o < N_PORTS; o++)
            begin
                oshift_reg[o] <= '0;
            end
        end
        else
        begin
            oshift_reg <= oshift_next;
            odata_reg  <= odata_next;
            ossf_reg   <= ossf_next;
            ofs_reg    <= ofs_next;
            oclk_reg   <= {N_PORTS{ref_clk}};
        end
    end

    // Access point arbitration: a grant holds until its request drops.
    logic [N_SOURCES-1:0] grant_reg;
    logic [N_SOURCES-1:0] grant_next;

    always_comb
    begin
        grant_next = grant_reg & source_request;
        if (grant_next == '0)
        begin
            for (int s = N_SOURCES - 1; s >= 0; s--)
            begin
                if (source_request[s])
                begin
                    grant_next = '0;
                    grant_next[s] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        grant_reg <= reset ? '0 : grant_next;
    end

    assign out_bit_clock   = oclk_reg;
    assign out_data        = odata_reg;
    assign out_frame_start = ofs_reg;
    assign out_server_fail = ossf_reg;
    assign source_grant    = grant_reg;
    assign cmd_done        = done_reg;
    assign cmd_error       = err_reg;

    chk_grant_onehot: assert property (@(posedge clk_sys) disable iff (reset) $onehot0(grant_reg))
        else $error("More than one source granted.");
    chk_grant_holds: assert property (@(posedge clk_sys) disable iff (reset)
        ((grant_reg & source_request) != '0) |=> grant_reg == $past(grant_reg))
        else $error("Held grant was taken away.");
    chk_sink_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        load |=> (out_server_fail & ~$past(sink_active)) == '0)
        else $error("Inactive sink saw server fail.");
    chk_connect_entry: assert property (@(posedge clk_sys) disable iff (reset)
        (cmd_valid && ids_ok && cmd.op == CMD_CONNECT) |=>
        map_reg[$past(cmd.out_id)].connected && map_reg[$past(cmd.out_id)].src == $past(cmd.in_id) && cmd_done)
        else $error("Connect not applied.");
    chk_disconnect_entry: assert property (@(posedge clk_sys) disable iff (reset)
        (cmd_valid && ids_ok && cmd.op == CMD_DISCONNECT) |=> !map_reg[$past(cmd.out_id)].connected)
        else $error("Disconnect not applied.");
    chk_bidir_reverse: assert property (@(posedge clk_sys) disable iff (reset)
        (cmd_valid && ids_ok && cmd.op == CMD_CONNECT && cmd.conn_direction == DIR_BI) |=>
        map_reg[$past(cmd.in_id)].src == $past(cmd.out_id))
        else $error("Reverse leg missing.");
    chk_idle_output: assert property (@(posedge clk_sys) disable iff (reset)
        (load && !map_reg[0].connected && map_reg[0].law == LAW_A) |=>
        oshift_reg[0] == IDLE_ALAW && !out_server_fail[0] ##1 out_data[0] == IDLE_ALAW[7])
        else $error("Idle octet wrong.");
    chk_fs_retimed: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(out_frame_start[0]) |-> $past(load))
        else $error("Frame start not on reference.");
    chk_routed_octet: assert property (@(posedge clk_sys) disable iff (reset)
        (load && map_reg[0].connected) |=>
        oshift_reg[0] == $past(store_data_reg[map_reg[0].src]) && out_data[0] == oshift_reg[0][7])
        else $error("Routed octet altered.");

endmodule : channel_connection_matrix
`default_nettype wire

// >>> test/channel_source.sv
// Serial source model standing on every input connection point of the matrix.
// Assumes one free-running 160 ns bit clock shared by all input channels.
`timescale 1ns/10ps
`default_nettype none
module channel_source #(
    parameter int N_PORTS = 6
)
(
    // Octets and fail flags to send, one per port
    input  wire logic [N_PORTS-1:0][7:0] octets,
    input  wire logic [N_PORTS-1:0]      fail,
    // Channel pins
    output var logic  [N_PORTS-1:0]      bit_clock,
    output var logic  [N_PORTS-1:0]      data,
    output var logic  [N_PORTS-1:0]      frame_start,
    output var logic  [N_PORTS-1:0]      server_fail
);
    // Lines change half a bit before the rising edge that samples them.
    initial
    begin
        bit_clock = '0;
        data = '0;
        frame_start = '0;
        server_fail = '0;
        #37;
        forever
        begin
            for (int b = 0; b < 8; b++)
            begin
                for (int p = 0; p < N_PORTS; p++)
                begin
                    data[p] = octets[p][7-b];
                end
                frame_start = {N_PORTS{b == 0}};
                server_fail = fail;
                #80;
                bit_clock = '1;
                #80;
                bit_clock = '0;
            end
        end
    end
endmodule : channel_source
`default_nettype wire

// >>> test/channel_connection_matrix_bench.sv
// Self-checking bench for the channel connection matrix.
// Assumes the source model on the inputs and a 160 ns reference clock made here.
`timescale 1ns/10ps
`default_nettype none
module channel_connection_matrix_bench;
    import conn_matrix_pkg::*;
    localparam int NP = 6;
    logic                clk_sys, reset, ref_clk, ref_fs, cmd_valid, cmd_done, cmd_error;
    logic [NP-1:0]       in_clk, in_d, in_fs, in_ssf, o_clk, o_d, o_fs, o_ssf, sink_active, src_fail;
    logic [NP-1:0][7:0]  octets;
    logic [3:0]          source_request, source_grant;
    conn_cmd_s           cmd;
    int                  fails, n_tests;

    channel_source #(.N_PORTS(NP)) channel_source_inst (.octets(octets), .fail(src_fail),
        .bit_clock(in_clk), .data(in_d), .frame_start(in_fs), .server_fail(in_ssf));

    channel_connection_matrix #(.N_PORTS(NP), .N_SOURCES(4)) channel_connection_matrix_inst (
        .clk_sys(clk_sys), .reset(reset), .in_bit_clock(in_clk), .in_data(in_d),
        .in_frame_start(in_fs), .in_server_fail(in_ssf), .timing_ref_clock(ref_clk),
        .timing_ref_frame_start(ref_fs), .out_bit_clock(o_clk), .out_data(o_d),
        .out_frame_start(o_fs), .out_server_fail(o_ssf), .sink_active(sink_active),
        .source_request(source_request), .source_grant(source_grant), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_done(cmd_done), .cmd_error(cmd_error));

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_flags(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flags

    task automatic send_cmd(input cmd_op_e op, input logic [2:0] i, input logic [2:0] o,
                            input conn_direction_e d, input idle_law_e law, input logic err);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd = '{op, i, o, d, law};
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        check_flags("cmd_done", 4'h1, {3'h0, cmd_done});
        check_flags("cmd_error", {3'h0, err}, {3'h0, cmd_error});
    endtask : send_cmd

    task automatic wait_fs(input int p, input logic lvl);
        int k;
        k = 0;
        while (o_fs[p] !== lvl)
        begin
            @(negedge clk_sys);
            k++;
            if (k > 600)
            begin
                fails++;
                $display("[ERR] out_frame_start expected %b seen timeout", lvl);
                finish_test();
            end
        end
    endtask : wait_fs

    // Skips one whole frame so a new map or flag has surely reached the output.
    task automatic check_out(input int p, input logic [7:0] eb, input logic es);
        logic [7:0]    got;
        logic          gs;
        logic [NP-1:0] ck;
        logic [1:0]    fs2;
        repeat (2)
        begin
            wait_fs(p, 1'b0);
            wait_fs(p, 1'b1);
        end
        repeat (8) @(negedge clk_sys);
        gs = o_ssf[p];
        ck = o_clk;
        fs2[1] = o_fs[p];
        for (int b = 7; b >= 0; b--)
        begin
            got[b] = o_d[p];
            if (b > 0)
                repeat (32) @(negedge clk_sys);
        end
        fs2[0] = o_fs[p];
        repeat (16) @(negedge clk_sys);
        check_byte("out_data", eb, got);
        check_flags("out_server_fail", {3'h0, es}, {3'h0, gs});
        check_byte("out_bit_clock high", 8'h3f, {2'h0, ck});
        check_byte("out_bit_clock low", 8'h00, {2'h0, o_clk});
        check_flags("out_frame_start", 4'h2, {2'h0, fs2});
    endtask : check_out

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Reference timing, phase unrelated to clk_sys.
    initial
    begin
        ref_clk = 1'b0;
        ref_fs = 1'b0;
        #53;
        forever
        begin
            for (int b = 0; b < 8; b++)
            begin
                ref_fs = (b == 0);
                #80;
                ref_clk = 1'b1;
                #80;
                ref_clk = 1'b0;
            end
        end
    end

    initial
    begin
        fails = 0;
        n_tests = 0;
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        sink_active = '1;
        source_request = '0;
        src_fail = 6'h04;
        for (int p = 0; p < NP; p++)
            octets[p] = 8'h3c ^ (8'h17 * p[7:0]);
        repeat (4) @(negedge clk_sys);
        reset = 1'b0;
        check_out(0, IDLE_ALAW, 1'b0);
        send_cmd(CMD_CONNECT, 3'h2, 3'h0, DIR_UNI, LAW_A, 1'b0);
        check_out(0, octets[2], 1'b1);
        send_cmd(CMD_CONNECT, 3'h2, 3'h1, DIR_UNI, LAW_A, 1'b0);
        check_out(1, octets[2], 1'b1);
        check_out(0, octets[2], 1'b1);
        @(negedge clk_sys);
        sink_active[1] = 1'b0;
        check_out(1, octets[2], 1'b0);
        @(negedge clk_sys);
        sink_active[1] = 1'b1;
        send_cmd(CMD_CONNECT, 3'h5, 3'h3, DIR_BI, LAW_A, 1'b0);
        check_out(3, octets[5], 1'b0);
        check_out(5, octets[3], 1'b0);
        send_cmd(CMD_DISCONNECT, 3'h5, 3'h3, DIR_UNI, LAW_A, 1'b0);
        check_out(5, IDLE_ALAW, 1'b0);
        send_cmd(CMD_DISCONNECT, 3'h2, 3'h0, DIR_UNI, LAW_MU, 1'b0);
        check_out(0, IDLE_MULAW, 1'b0);
        check_out(1, octets[2], 1'b1);
        send_cmd(CMD_CONNECT, 3'h7, 3'h1, DIR_UNI, LAW_A, 1'b1);
        check_out(1, octets[2], 1'b1);
        @(negedge clk_sys);
        source_request = 4'h6;
        repeat (2) @(negedge clk_sys);
        check_flags("source_grant", 4'h2, source_grant);
        source_request = 4'h7;
        repeat (2) @(negedge clk_sys);
        check_flags("source_grant", 4'h2, source_grant);
        source_request = 4'h4;
        repeat (3) @(negedge clk_sys);
        check_flags("source_grant", 4'h4, source_grant);
        finish_test();
    end
endmodule : channel_connection_matrix_bench
`default_nettype wire
